// *** sbc_smart_boost_control.sv ***
// Top of the smart boost control: register file, mode decode and rail request.
//
// Summary of operation
// (RULE_01) In a smart mode the rail is raised once amplitude exceeds attack code times full scale over 64.
// (RULE_02) In a smart mode the rail is not raised while amplitude stays below release code times full scale over 64.
// (RULE_03) The 3-bit mode field picks transparent 0, forced 1, smart 5 or smart 6, other codes being reserved.
// (RULE_04) Small-signal detection is deglitched by 1.33 ms up to 2.73 s as chosen by a 3-bit field.
// (RULE_05) A 4-bit field sets the maximum rail voltage from 6.5 V at code 0 in 0.25 V steps to 10.25 V.
// (RULE_06) The battery voltage is readable as a 10-bit value scaled to 6.025 V over 1023.
// (RULE_07) Die temperature is readable as a 10-bit two's complement value in one-degree steps.
// (RULE_08) After reset attack is 0x2, release 0x4, mode 0x2, deglitch 0x6 and maximum voltage 0x8.
// (RULE_09) A 4-bit read-only field shows the voltage code actually applied to the rail.
// (RULE_10) Transparent mode never raises the rail and forced mode targets the maximum voltage always.
`timescale 1ns/10ps
`default_nettype none
module sbc_smart_boost_control
#(
   parameter int AMP_W       = 16,
   parameter int DEG0_CYCLES = sbc_pkg::SBC_DEG0_CYCLES,
   parameter int DEG1_CYCLES = sbc_pkg::SBC_DEG1_CYCLES,
   parameter int DEG2_CYCLES = sbc_pkg::SBC_DEG2_CYCLES,
   parameter int DEG3_CYCLES = sbc_pkg::SBC_DEG3_CYCLES,
   parameter int DEG4_CYCLES = sbc_pkg::SBC_DEG4_CYCLES,
   parameter int DEG5_CYCLES = sbc_pkg::SBC_DEG5_CYCLES,
   parameter int DEG6_CYCLES = sbc_pkg::SBC_DEG6_CYCLES,
   parameter int DEG7_CYCLES = sbc_pkg::SBC_DEG7_CYCLES
)
(
   input  wire logic             clk_sys_i,
   input  wire logic             resetn_i,
   input  wire logic [7:0]       reg_addr_i,
   input  wire logic             reg_wr_i,
   input  wire logic             reg_rd_i,
   input  wire logic [15:0]      reg_wdata_i,
   output var  logic [15:0]      reg_rdata_o,
   output var  logic             reg_rvalid_o,
   input  wire logic [AMP_W-1:0] amplitude_i,
   input  wire logic [9:0]       battery_level_sample_i,
   input  wire logic [9:0]       die_heat_sample_i,
   output var  logic             converter_output_rail_raise_o,
   output var  logic [3:0]       applied_voltage_code_o,
   output var  logic [2:0]       converter_mode_select_o
);
   import sbc_pkg::*;

   // =========================================================================
   // State
   typedef struct packed {
      logic [5:0]  attack_threshold;
      logic [5:0]  release_threshold;
      logic [2:0]  converter_mode_select;
      logic [2:0]  small_signal_deglitch_sel;
      logic [3:0]  max_output_voltage_code;
      logic [9:0]  battery_level_reading;
      logic [9:0]  die_heat_reading;
      logic [3:0]  applied_voltage_code;
      logic        rail_raise;
      logic [15:0] rdata;
      logic        rvalid;
   } sbc_ctrl_s;

   localparam sbc_ctrl_s SBC_CTRL_RST = '{
      attack_threshold:          SBC_ATH_RST,
      release_threshold:         SBC_RTH_RST,
      converter_mode_select:     SBC_MODE_RST,
      small_signal_deglitch_sel: SBC_TDEG_RST,
      max_output_voltage_code:   SBC_VOUT_RST,
      battery_level_reading:     SBC_BATTERY_RST,
      die_heat_reading:          SBC_DIE_TEMP_RST,
      applied_voltage_code:      SBC_APPLIED_RST,
      rail_raise:                1'b0,
      rdata:                     16'h0000,
      rvalid:                    1'b0
   };

   sbc_ctrl_s ctrl_q;
   sbc_ctrl_s ctrl_d;

   sbc_det_if #(.AMP_W(AMP_W)) det_bus ();

   // =========================================================================
   // Helpers
   function automatic logic is_smart(input logic [2:0] mode);
      return (mode == SBC_MODE_SMART_1) || (mode == SBC_MODE_SMART_2); // RULE_03
   endfunction

   function automatic logic [SBC_DEG_W-1:0] deg_count(input logic [2:0] sel);
      logic [SBC_DEG_W-1:0] c;
      case (sel)
         3'h0:    c = SBC_DEG_W'(DEG0_CYCLES);
         3'h1:    c = SBC_DEG_W'(DEG1_CYCLES);
         3'h2:    c = SBC_DEG_W'(DEG2_CYCLES);
         3'h3:    c = SBC_DEG_W'(DEG3_CYCLES);
         3'h4:    c = SBC_DEG_W'(DEG4_CYCLES);
         3'h5:    c = SBC_DEG_W'(DEG5_CYCLES);
         3'h6:    c = SBC_DEG_W'(DEG6_CYCLES);
         default: c = SBC_DEG_W'(DEG7_CYCLES);
      endcase
      return c; // RULE_04
   endfunction

   // =========================================================================
   // Detector hookup
   assign det_bus.amplitude         = amplitude_i;
   assign det_bus.attack_threshold  = ctrl_q.attack_threshold;
   assign det_bus.release_threshold = ctrl_q.release_threshold;
   assign det_bus.smart_en          = is_smart(ctrl_q.converter_mode_select);
   assign det_bus.deg_cycles        = deg_count(ctrl_q.small_signal_deglitch_sel);

   sbc_detector #(.AMP_W(AMP_W)) u_detector
   (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .det       (det_bus.det)
   );

   // =========================================================================
   // Next state
   always_comb
   begin
      ctrl_d = ctrl_q;

      // Readings are refreshed every cycle; the sources are already synchronous.
      ctrl_d.battery_level_reading = battery_level_sample_i; // RULE_06
      ctrl_d.die_heat_reading      = die_heat_sample_i; // RULE_07

      case (ctrl_q.converter_mode_select)
         SBC_MODE_FORCED:
         begin
            ctrl_d.rail_raise = 1'b1; // RULE_10
         end
         SBC_MODE_SMART_1,
         SBC_MODE_SMART_2:
         begin
            ctrl_d.rail_raise = det_bus.raise; // RULE_01 RULE_02
         end
         default:
         begin
            // Transparent and reserved codes both pass the supply through, the safe choice.
            ctrl_d.rail_raise = 1'b0; // RULE_10 RULE_03
         end
      endcase
      ctrl_d.applied_voltage_code = ctrl_d.rail_raise ? ctrl_q.max_output_voltage_code
                                                      : SBC_APPLIED_RST; // RULE_09 RULE_05

      if (reg_wr_i)
      begin
         case (reg_addr_i)
            SBC_THRESHOLD_CTRL_ADDR:
            begin
               ctrl_d.attack_threshold  = reg_wdata_i[SBC_ATH_LSB +: 6]; // RULE_01
               ctrl_d.release_threshold = reg_wdata_i[SBC_RTH_LSB +: 6]; // RULE_02
            end
            SBC_MODE_CTRL_ADDR:
            begin
               ctrl_d.converter_mode_select     = reg_wdata_i[SBC_MODE_LSB +: 3]; // RULE_03
               ctrl_d.small_signal_deglitch_sel = reg_wdata_i[SBC_TDEG_LSB +: 3]; // RULE_04
            end
            SBC_MAX_VOLT_CTRL_ADDR:
            begin
               ctrl_d.max_output_voltage_code = reg_wdata_i[SBC_VOUT_LSB +: 4]; // RULE_05
            end
            default:
            begin
               ctrl_d.rvalid = ctrl_q.rvalid;
            end
         endcase
      end

      ctrl_d.rvalid = reg_rd_i;
      ctrl_d.rdata  = 16'h0000;
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            SBC_THRESHOLD_CTRL_ADDR:
            begin
               ctrl_d.rdata[SBC_ATH_LSB +: 6] = ctrl_q.attack_threshold;
               ctrl_d.rdata[SBC_RTH_LSB +: 6] = ctrl_q.release_threshold;
            end
            SBC_MODE_CTRL_ADDR:
            begin
               ctrl_d.rdata[SBC_MODE_LSB +: 3] = ctrl_q.converter_mode_select;
               ctrl_d.rdata[SBC_TDEG_LSB +: 3] = ctrl_q.small_signal_deglitch_sel;
            end
            SBC_MAX_VOLT_CTRL_ADDR:
            begin
               ctrl_d.rdata[SBC_VOUT_LSB +: 4] = ctrl_q.max_output_voltage_code;
            end
            SBC_BATTERY_READ_ADDR:
            begin
               ctrl_d.rdata[SBC_READ_LSB +: 10] = ctrl_q.battery_level_reading; // RULE_06
            end
            SBC_DIE_TEMP_READ_ADDR:
            begin
               ctrl_d.rdata[SBC_READ_LSB +: 10] = ctrl_q.die_heat_reading; // RULE_07
            end
            SBC_APPLIED_VOLT_ADDR:
            begin
               ctrl_d.rdata[SBC_READ_LSB +: 4] = ctrl_q.applied_voltage_code; // RULE_09
            end
            default:
            begin
               ctrl_d.rdata = 16'h0000;
            end
         endcase
      end
   end

   // =========================================================================
   // Registers
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ctrl_q <= SBC_CTRL_RST; // RULE_08
      end
      else
      begin
         ctrl_q <= ctrl_d;
      end
   end

   // =========================================================================
   // Outputs
   assign reg_rdata_o                   = ctrl_q.rdata;
   assign reg_rvalid_o                  = ctrl_q.rvalid;
   assign converter_output_rail_raise_o = ctrl_q.rail_raise;
   assign applied_voltage_code_o        = ctrl_q.applied_voltage_code;
   assign converter_mode_select_o       = ctrl_q.converter_mode_select;

endmodule
`default_nettype wire

// *** sbc_pkg.sv ***
// Package with register map, reset values and timing constants of the smart boost control.
package sbc_pkg;

   // ==========================================================================
   // Register offsets
   localparam logic [7:0] SBC_THRESHOLD_CTRL_ADDR = 8'h60;
   localparam logic [7:0] SBC_MODE_CTRL_ADDR      = 8'h61;
   localparam logic [7:0] SBC_MAX_VOLT_CTRL_ADDR  = 8'h62;
   localparam logic [7:0] SBC_BATTERY_READ_ADDR   = 8'h6D;
   localparam logic [7:0] SBC_DIE_TEMP_READ_ADDR  = 8'h6E;
   localparam logic [7:0] SBC_APPLIED_VOLT_ADDR   = 8'h10;

   // ==========================================================================
   // Field positions
   localparam int SBC_ATH_LSB   = 0;
   localparam int SBC_RTH_LSB   = 8;
   localparam int SBC_TDEG_LSB  = 0;
   localparam int SBC_MODE_LSB  = 4;
   localparam int SBC_VOUT_LSB  = 0;
   localparam int SBC_READ_LSB  = 0;

   // ==========================================================================
   // Reset values
   localparam logic [5:0] SBC_ATH_RST      = 6'h02;
   localparam logic [5:0] SBC_RTH_RST      = 6'h04;
   localparam logic [2:0] SBC_MODE_RST     = 3'h2;
   localparam logic [2:0] SBC_TDEG_RST     = 3'h6;
   localparam logic [3:0] SBC_VOUT_RST     = 4'h8;
   localparam logic [9:0] SBC_BATTERY_RST  = 10'h263;
   localparam logic [9:0] SBC_DIE_TEMP_RST = 10'h019;
   localparam logic [3:0] SBC_APPLIED_RST  = 4'h0;

   // ==========================================================================
   // Converter modes
   typedef enum logic [2:0] {
      SBC_MODE_TRANSPARENT = 3'h0,
      SBC_MODE_FORCED      = 3'h1,
      SBC_MODE_SMART_1     = 3'h5,
      SBC_MODE_SMART_2     = 3'h6
   } sbc_mode_e;

   // ==========================================================================
   // Deglitch times in microseconds and their cycle counts at the system clock
   localparam int SBC_CLK_MHZ     = 40;
   localparam int SBC_DEG_W       = 27;
   localparam int SBC_DEG0_US     = 1330;
   localparam int SBC_DEG1_US     = 2660;
   localparam int SBC_DEG2_US     = 5320;
   localparam int SBC_DEG3_US     = 21300;
   localparam int SBC_DEG4_US     = 85200;
   localparam int SBC_DEG5_US     = 340790;
   localparam int SBC_DEG6_US     = 1363000;
   localparam int SBC_DEG7_US     = 2730000;
   localparam int SBC_DEG0_CYCLES = SBC_DEG0_US * SBC_CLK_MHZ;
   localparam int SBC_DEG1_CYCLES = SBC_DEG1_US * SBC_CLK_MHZ;
   localparam int SBC_DEG2_CYCLES = SBC_DEG2_US * SBC_CLK_MHZ;
   localparam int SBC_DEG3_CYCLES = SBC_DEG3_US * SBC_CLK_MHZ;
   localparam int SBC_DEG4_CYCLES = SBC_DEG4_US * SBC_CLK_MHZ;
   localparam int SBC_DEG5_CYCLES = SBC_DEG5_US * SBC_CLK_MHZ;
   localparam int SBC_DEG6_CYCLES = SBC_DEG6_US * SBC_CLK_MHZ;
   localparam int SBC_DEG7_CYCLES = SBC_DEG7_US * SBC_CLK_MHZ;

endpackage

// *** sbc_det_if.sv ***
// Interface between the register block and the amplitude detector.
`timescale 1ns/10ps
`default_nettype none
interface sbc_det_if
#(
   parameter int AMP_W = 16
);
   import sbc_pkg::*;

   logic [AMP_W-1:0]     amplitude;
   logic [5:0]           attack_threshold;
   logic [5:0]           release_threshold;
   logic                 smart_en;
   logic [SBC_DEG_W-1:0] deg_cycles;
   logic                 raise;

   modport ctrl
   (
      output amplitude,
      output attack_threshold,
      output release_threshold,
      output smart_en,
      output deg_cycles,
      input  raise
   );

   modport det
   (
      input  amplitude,
      input  attack_threshold,
      input  release_threshold,
      input  smart_en,
      input  deg_cycles,
      output raise
   );
endinterface
`default_nettype wire

// *** sbc_detector.sv ***
// Amplitude detector with attack, release and small-signal deglitch.
`timescale 1ns/10ps
`default_nettype none
module sbc_detector
#(
   parameter int AMP_W = 16
)
(
   input  wire logic clk_sys_i,
   input  wire logic resetn_i,
   sbc_det_if.det    det
);
   import sbc_pkg::*;

   // =========================================================================
   // State
   typedef enum logic [1:0] {
      SBC_DET_IDLE  = 2'b00,
      SBC_DET_BOOST = 2'b01,
      SBC_DET_HOLD  = 2'b11
   } sbc_det_e;

   typedef struct packed {
      sbc_det_e             state;
      logic [SBC_DEG_W-1:0] cnt;
   } sbc_det_s;

   sbc_det_s det_q;
   sbc_det_s det_d;

   // Thresholds are code times one sixty-fourth of full scale.
   function automatic logic [AMP_W-1:0] scale_thr(input logic [5:0] code);
      return {code, {(AMP_W-6){1'b0}}};
   endfunction

   logic above_attack;
   logic below_release;

   assign above_attack  = det.amplitude > scale_thr(det.attack_threshold); // RULE_01
   assign below_release = det.amplitude < scale_thr(det.release_threshold); // RULE_02

   // =========================================================================
   // Next state
   always_comb
   begin
      det_d = det_q;
      case (det_q.state)
         SBC_DET_IDLE:
         begin
            det_d.cnt = '0;
            if (det.smart_en && above_attack)
            begin
               det_d.state = SBC_DET_BOOST; // RULE_01
            end
         end
         SBC_DET_BOOST:
         begin
            det_d.cnt = '0;
            if (!det.smart_en)
            begin
               det_d.state = SBC_DET_IDLE;
            end
            else if (below_release)
            begin
               det_d.state = SBC_DET_HOLD;
            end
         end
         SBC_DET_HOLD:
         begin
            // A short dip below release must not drop the rail; it must last the deglitch time.
            if (!det.smart_en)
            begin
               det_d.state = SBC_DET_IDLE;
            end
            else if (!below_release)
            begin
               det_d.state = SBC_DET_BOOST;
            end
            else if (det_q.cnt >= det.deg_cycles - SBC_DEG_W'(1))
            begin
               det_d.state = SBC_DET_IDLE; // RULE_04 RULE_02
            end
            else
            begin
               det_d.cnt = det_q.cnt + SBC_DEG_W'(1); // RULE_04
            end
         end
         default:
         begin
            det_d.state = SBC_DET_IDLE;
            det_d.cnt   = '0;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         det_q <= '{state: SBC_DET_IDLE, cnt: '0};
      end
      else
      begin
         det_q <= det_d;
      end
   end

   assign det.raise = (det_q.state != SBC_DET_IDLE);

endmodule
`default_nettype wire

// *** sbc_smart_boost_control_chk.sv ***
// Checker with the concurrent assertions of the smart boost control top.
`timescale 1ns/10ps
`default_nettype none
module sbc_smart_boost_control_chk
#(
   parameter int AMP_W = 16
)
(
   input  wire logic             clk_sys_i,
   input  wire logic             resetn_i,
   input  wire logic [7:0]       reg_addr_i,
   input  wire logic             reg_wr_i,
   input  wire logic             reg_rd_i,
   input  wire logic [15:0]      reg_wdata_i,
   input  wire logic [15:0]      reg_rdata_o,
   input  wire logic             reg_rvalid_o,
   input  wire logic [AMP_W-1:0] amplitude_i,
   input  wire logic [9:0]       battery_level_sample_i,
   input  wire logic [9:0]       die_heat_sample_i,
   input  wire logic             converter_output_rail_raise_o,
   input  wire logic [3:0]       applied_voltage_code_o,
   input  wire logic [2:0]       converter_mode_select_o
);
   import sbc_pkg::*;
   // ==========================================================================
   // Shadow of the writable fields other than the deglitch select
   logic [5:0]       ath_q;
   logic [5:0]       rth_q;
   logic [2:0]       mode_q;
   logic [3:0]       vout_q;
   logic [AMP_W-1:0] ath_thr;
   logic             smart;
   logic             raise;
   assign ath_thr = AMP_W'(ath_q) << (AMP_W - 6);
   assign smart   = (mode_q == 3'h5) || (mode_q == 3'h6);
   assign raise   = converter_output_rail_raise_o;
   always_ff @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ath_q  <= SBC_ATH_RST;
         rth_q  <= SBC_RTH_RST;
         mode_q <= SBC_MODE_RST;
         vout_q <= SBC_VOUT_RST;
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == SBC_THRESHOLD_CTRL_ADDR)
         begin
            ath_q <= reg_wdata_i[5:0];
            rth_q <= reg_wdata_i[13:8];
         end
         if (reg_addr_i == SBC_MODE_CTRL_ADDR)
         begin
            mode_q <= reg_wdata_i[6:4];
         end
         if (reg_addr_i == SBC_MAX_VOLT_CTRL_ADDR)
         begin
            vout_q <= reg_wdata_i[3:0];
         end
      end
   end
   // ==========================================================================
   // Properties
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   property p_batt;
      reg_rd_i && reg_addr_i == SBC_BATTERY_READ_ADDR && $stable(battery_level_sample_i)
      |=> reg_rvalid_o && reg_rdata_o == {6'h00, $past(battery_level_sample_i)};
   endproperty
   a_batt: assert property (p_batt) else $error("Battery reading mismatch.");
   property p_temp;
      reg_rd_i && reg_addr_i == SBC_DIE_TEMP_READ_ADDR && $stable(die_heat_sample_i)
      |=> reg_rvalid_o && reg_rdata_o == {6'h00, $past(die_heat_sample_i)};
   endproperty
   a_temp: assert property (p_temp) else $error("Temperature reading mismatch.");
   property p_thr;
      reg_rd_i && reg_addr_i == SBC_THRESHOLD_CTRL_ADDR |=> reg_rdata_o == {2'h0, $past(rth_q), 2'h0, $past(ath_q)};
   endproperty
   a_thr: assert property (p_thr) else $error("Threshold read mismatch.");
   property p_mode;
      converter_mode_select_o == mode_q;
   endproperty
   a_mode: assert property (p_mode) else $error("Mode output differs from mode field.");
   property p_transparent;
      (mode_q != 3'h1 && !smart) [*2] |-> !raise;
   endproperty
   a_transparent: assert property (p_transparent) else $error("Rail raised outside boost modes.");
   property p_forced;
      (mode_q == 3'h1) [*2] |-> raise;
   endproperty
   a_forced: assert property (p_forced) else $error("Forced mode did not raise the rail.");
   property p_attack;
      (smart && amplitude_i > ath_thr) ##1 smart [*2] |-> ##[0:1] raise;
   endproperty
   a_attack: assert property (p_attack) else $error("Attack crossing did not raise the rail.");
   property p_quiet;
      (smart && amplitude_i <= ath_thr) [*3] ##0 !raise |=> !raise;
   endproperty
   a_quiet: assert property (p_quiet) else $error("Rail raised without an attack crossing.");
   property p_applied;
      vout_q == $past(vout_q) |-> applied_voltage_code_o == (raise ? vout_q : 4'h0);
   endproperty
   a_applied: assert property (p_applied) else $error("Applied voltage code mismatch.");
   c_forced: cover property ((mode_q == 3'h1) ##1 raise);
   c_smart_fall: cover property (smart && raise ##1 !raise);
   c_read: cover property (reg_rd_i ##1 reg_rvalid_o);
endmodule
bind sbc_smart_boost_control sbc_smart_boost_control_chk #(.AMP_W(AMP_W)) sbc_chk_inst
(
   .clk_sys_i                     (clk_sys_i),
   .resetn_i                      (resetn_i),
   .reg_addr_i                    (reg_addr_i),
   .reg_wr_i                      (reg_wr_i),
   .reg_rd_i                      (reg_rd_i),
   .reg_wdata_i                   (reg_wdata_i),
   .reg_rdata_o                   (reg_rdata_o),
   .reg_rvalid_o                  (reg_rvalid_o),
   .amplitude_i                   (amplitude_i),
   .battery_level_sample_i        (battery_level_sample_i),
   .die_heat_sample_i             (die_heat_sample_i),
   .converter_output_rail_raise_o (converter_output_rail_raise_o),
   .applied_voltage_code_o        (applied_voltage_code_o),
   .converter_mode_select_o       (converter_mode_select_o)
);
`default_nettype wire

// *** sbc_stage_model.sv ***
// Behavioural model of the analog stage: amplitude path and converters.
`timescale 1ns/10ps
`default_nettype none
module sbc_stage_model
#(
   parameter int AMP_W = 16
)
(
   input  wire logic             clk_sys_i,
   input  wire logic [AMP_W-1:0] level_i,
   input  wire logic [9:0]       battery_set_i,
   input  wire logic [9:0]       heat_set_i,
   output var  logic [AMP_W-1:0] amplitude_o,
   output var  logic [9:0]       battery_o,
   output var  logic [9:0]       heat_o
);
   // ==========================================================================
   // Amplitude path
   // The envelope lags one clock, as a real detector never reports in the same cycle.
   // The converters lag one clock as well, so a new reading needs two edges to become readable.
   always_ff @(posedge clk_sys_i)
   begin
      amplitude_o <= level_i;
      battery_o   <= battery_set_i;
      heat_o      <= heat_set_i;
   end
endmodule
`default_nettype wire

// *** sbc_smart_boost_control_bench.sv ***
// Self-checking testbench of the smart boost control.
`timescale 1ns/10ps
`default_nettype none
module sbc_smart_boost_control_bench;
   import sbc_pkg::*;
   logic        clk_sys_i, resetn_i, reg_wr_i, reg_rd_i, reg_rvalid_o, raise, exp_raise;
   logic [7:0]  reg_addr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o, level, amplitude;
   logic [9:0]  battery, heat, batt_set, heat_set;
   localparam int DEG_STEP = 10;
   logic [3:0]  applied;
   logic [2:0]  mode;
   int          failures, n_compared, n, dev;
   sbc_stage_model sbc_stage_model_inst (.clk_sys_i(clk_sys_i), .level_i(level), .battery_set_i(batt_set),
      .heat_set_i(heat_set), .amplitude_o(amplitude), .battery_o(battery), .heat_o(heat));
   // Short deglitch counts keep the release scenarios brief; the ratios between codes do not matter here.
   sbc_smart_boost_control #(.DEG0_CYCLES(DEG_STEP), .DEG1_CYCLES(DEG_STEP * 2), .DEG2_CYCLES(DEG_STEP * 3),
      .DEG3_CYCLES(DEG_STEP * 4), .DEG4_CYCLES(DEG_STEP * 5), .DEG5_CYCLES(DEG_STEP * 6),
      .DEG6_CYCLES(DEG_STEP * 7), .DEG7_CYCLES(DEG_STEP * 8)) sbc_smart_boost_control_inst
      (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
      .amplitude_i(amplitude), .battery_level_sample_i(battery), .die_heat_sample_i(heat),
      .converter_output_rail_raise_o(raise), .applied_voltage_code_o(applied),
      .converter_mode_select_o(mode));
   // ==========================================================================
   // Access tasks
   task automatic summarize;
      $display("Compared %0d, mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got 0x%h expected 0x%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys_i);
      #2;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      cyc(1);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      cyc(1);
      reg_wr_i = 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
      cyc(1);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      cyc(1);
      chk(reg_rvalid_o === 1'b1 ? reg_rdata_o : 16'hBAD0, exp);
      reg_rd_i = 1'b0;
   endtask
   // ==========================================================================
   // Clock and watchdog
   initial
   begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   initial
   begin
      #(25 * 20000);
      failures++;
      summarize();
   end
   // ==========================================================================
   // Tests
   initial
   begin
      {resetn_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, level, failures, n_compared} = '0;
      batt_set = 10'h2A5;
      heat_set = 10'h3D8;
      cyc(8);
      resetn_i = 1'b1;
      rdc(8'h60, 16'h0402);
      rdc(8'h61, 16'h0026);
      rdc(8'h62, 16'h0008);
      rdc(8'h6E, 16'h03D8);
      rdc(8'h10, 16'h0000);
      wr(8'h6D, 16'h0000);
      rdc(8'h6D, 16'h02A5);
      heat_set = 10'h019;
      batt_set = 10'h3FF;
      cyc(1);
      rdc(8'h6E, 16'h0019);
      rdc(8'h6D, 16'h03FF);
      wr(8'h55, 16'hFFFF);
      rdc(8'h60, 16'h0402);
      rdc(8'h55, 16'h0000);
      wr(8'h60, 16'hFFFF);
      rdc(8'h60, 16'h3F3F);
      wr(8'h62, 16'hFFFF);
      rdc(8'h62, 16'h000F);
      wr(8'h62, 16'h000B);
      wr(8'h60, 16'h0102);
      // Every mode code with a loud signal; reserved codes must behave as transparent.
      for (int c = 0; c < 8; c++)
      begin
         wr(SBC_MODE_CTRL_ADDR, {9'h000, 3'(c), 4'h0});
         level = 16'hFFFF;
         cyc(5);
         exp_raise = (c == 1 || c == 5 || c == 6);
         chk({5'h00, mode, 3'h0, raise, applied}, {5'h00, 3'(c), 3'h0, exp_raise, exp_raise ? 4'hB : 4'h0});
         if (c == 1)
            rdc(8'h10, 16'h000B);
         level = 16'h0000;
      end
      wr(SBC_MODE_CTRL_ADDR, 16'h0050);
      level = 16'h0800;
      cyc(6);
      chk({15'h0, raise}, 16'h0000);
      level = 16'h0801;
      cyc(4);
      chk({15'h0, raise}, 16'h0001);
      level = 16'h0400;
      cyc(40);
      chk({15'h0, raise}, 16'h0001);
      // Release timing for every deglitch code, then a level between the thresholds.
      for (int k = 0; k < 8; k++)
      begin
         wr(SBC_MODE_CTRL_ADDR, 16'h0050 | 16'(k));
         level = 16'hFFFF;
         cyc(4);
         level = 16'h03FF;
         n = 0;
         while (raise === 1'b1 && n < 200)
         begin
            cyc(1);
            n++;
         end
         // One clock of envelope lag, one to enter the hold, the deglitch count, one for the output flop.
         dev = DEG_STEP * (k + 1) + 3;
         chk(16'(n), 16'(dev));
         level = 16'h0500;
         cyc(20);
         chk({15'h0, raise}, 16'h0000);
      end
      // A reset in mid-run with the rail raised must drop it and return the mode and maximum voltage fields to their reset values.
      wr(SBC_MODE_CTRL_ADDR, 16'h0010);
      cyc(2);
      chk({15'h0, raise}, 16'h0001);
      resetn_i = 1'b0;
      cyc(2);
      resetn_i = 1'b1;
      chk({15'h0, raise}, 16'h0000);
      rdc(8'h61, 16'h0026);
      rdc(8'h62, 16'h0008);
      rdc(8'h10, 16'h0000);
      summarize();
   end
endmodule
`default_nettype wire
